// >>> bench/count_source.sv
// partner: external count/gate pin source
`timescale 1ns/1ps
`default_nettype none
module count_source #(
  parameter int HOLD = 12
) (
  input  wire logic mclk,
  input  wire logic toggle_en,
  input  wire logic idle_level,
  output logic      pin
);
  int   hold_cnt = 0;
  logic level    = 1'b1;
  assign pin = level;
  // levels change only at period ends, so no level is shorter than a machine cycle
  always @(posedge mclk) begin
    if (hold_cnt != HOLD - 1) begin
      hold_cnt <= hold_cnt + 1;
    end else begin
      hold_cnt <= 0;
      level    <= toggle_en ? !level : idle_level;
    end
  end
endmodule : count_source
`default_nettype wire

// >>> bench/tb_top.sv
// testbench: register access and counting scenarios for the dual timer/counter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [7:0] CTL = timer_pkg::IDX_CONTROL;
  localparam logic [7:0] MD  = timer_pkg::IDX_MODE;
  localparam logic [7:0] ZL  = timer_pkg::IDX_ZERO_LOW;
  localparam logic [7:0] ZH  = timer_pkg::IDX_ZERO_HIGH;
  localparam logic [7:0] OL  = timer_pkg::IDX_ONE_LOW;
  localparam logic [7:0] OH  = timer_pkg::IDX_ONE_HIGH;
  logic        mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata;
  logic        pready, pslverr, pin0, pin1, f0, f1, p0 = 1'b1, p1 = 1'b1;
  logic        tog = 1'b0, lvl = 1'b1, irq_pin = 1'b0, ack0 = 1'b0, ack1 = 1'b0;
  logic        baud;
  logic [1:0]  skew = 2'h0;
  int          n_errors = 0, comparisons = 0, edges0 = 0, edges1 = 0, n_baud = 0;
  always #2.5 mclk = ~mclk;
  count_source src0 (.mclk(mclk), .toggle_en(tog), .idle_level(lvl), .pin(pin0));
  count_source src1 (.mclk(mclk), .toggle_en(tog), .idle_level(lvl), .pin(pin1));
  dual_timer_counter uut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_count_in_zero(pin0), .ext_count_in_one(pin1),
    .ext_irq_pin_zero(irq_pin), .irq_ack_zero(ack0), .irq_ack_one(ack1),
    .overflow_flag_zero(f0), .overflow_flag_one(f1), .baud_tick_one(baud));
  always @(posedge mclk) begin
    p0 <= pin0;
    p1 <= pin1;
    if (p0 && !pin0) edges0++;
    if (p1 && !pin1) edges1++;
    if (baud) n_baud++;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd, output logic err);
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {2'b00, idx, skew};
    pwdata <= {24'h000000, wd};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] r;
    logic       e;
    apb(1'b1, idx, d, r, e);
  endtask : wr
  task automatic rchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] r;
    logic       e;
    apb(1'b0, idx, 8'h00, r, e);
    check(what, r, exp);
  endtask : rchk
  task automatic wait_flag(input bit both);
    for (int n = 0; n < 40 && !(f1 === 1'b1 && (f0 === 1'b1 || !both)); n++) @(posedge mclk);
  endtask : wait_flag
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // ------------------------------
  // scenarios
  // ------------------------------
  initial begin : main
    logic [7:0] r, hi, lo;
    logic       e;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    rchk("mode reset", MD, 8'h00);
    rchk("control reset", CTL, 8'h00);
    apb(1'b0, 8'h10, 8'h00, r, e);
    check("unmapped error", {7'h00, e}, 8'h01);
    skew = 2'h2;
    apb(1'b0, MD, 8'h00, r, e);
    skew = 2'h0;
    check("misaligned error", {7'h00, e}, 8'h01);
    wr(MD, 8'hA5);
    rchk("mode readback", MD, 8'hA5);
    $display("test registers done");
    wr(MD, 8'h11);
    wr(ZL, 8'h40);
    wr(CTL, 8'h10);
    repeat (117) @(posedge mclk); // run bit held exactly 120 core clocks
    wr(CTL, 8'h00);
    rchk("ten cycles counted", ZL, 8'h4A);
    repeat (40) @(posedge mclk);
    rchk("stopped count", ZL, 8'h4A);
    $display("test timer rate done");
    for (int m = 0; m < 3; m++) begin
      hi = (m == 2) ? 8'hF0 : 8'hFF;
      lo = (m == 0) ? 8'h1F : 8'hFF;
      wr(MD, {2'b00, 2'(m), 2'b00, 2'(m)});
      wr(ZH, hi);
      wr(OH, hi);
      wr(ZL, lo);
      wr(OL, lo);
      wr(CTL, 8'h50);
      wait_flag(1'b1);
      check("flag zero", {7'h00, f0}, 8'h01);
      check("flag one", {7'h00, f1}, 8'h01);
      wr(CTL, 8'hA0);
      rchk("high zero after wrap", ZH, (m == 2) ? 8'hF0 : 8'h00);
      rchk("low one after wrap", OL, (m == 2) ? 8'hF0 : 8'h00);
      rchk("low zero after wrap", ZL, (m == 2) ? 8'hF0 : 8'h00);
      ack0 <= 1'b1;
      ack1 <= 1'b1;
      @(posedge mclk);
      ack0 <= 1'b0;
      ack1 <= 1'b0;
      @(posedge mclk);
      check("flags acked", {6'h00, f1, f0}, 8'h00);
    end
    check("baud pulses", 8'(n_baud), 8'h03);
    $display("test wrap modes done");
    wr(MD, 8'h55);
    wr(ZL, 8'h00);
    wr(OL, 8'h00);
    wr(CTL, 8'h50);
    tog <= 1'b1;
    repeat (130) @(posedge mclk);
    tog <= 1'b0;
    repeat (60) @(posedge mclk);
    rchk("edges zero", ZL, 8'(edges0));
    rchk("edges one", OL, 8'(edges1));
    $display("test external edges done");
    wr(CTL, 8'h00);
    wr(MD, 8'h99);
    wr(ZL, 8'h00);
    lvl <= 1'b0;
    repeat (30) @(posedge mclk);
    wr(CTL, 8'h50);
    repeat (100) @(posedge mclk);
    rchk("gate closed", ZL, 8'h00);
    lvl <= 1'b1;
    repeat (100) @(posedge mclk);
    apb(1'b0, ZL, 8'h00, r, e);
    check("gate open", {7'h00, r != 8'h00}, 8'h01);
    $display("test gate done");
    wr(CTL, 8'h00);
    wr(MD, 8'h3B);
    wr(ZL, 8'h00);
    wr(ZH, 8'hFF);
    wr(OL, 8'h55);
    wr(CTL, 8'h50);
    wait_flag(1'b0);
    check("split flag one", {7'h00, f1}, 8'h01);
    rchk("split high wrapped", ZH, 8'h00);
    rchk("frozen timer one", OL, 8'h55);
    rchk("split low gated", ZL, 8'h00);
    irq_pin <= 1'b1;
    repeat (60) @(posedge mclk);
    apb(1'b0, ZL, 8'h00, r, e);
    check("split low counts", {7'h00, r != 8'h00}, 8'h01);
    $display("test split mode done");
    give_verdict();
  end
  initial begin : watchdog
    repeat (20000) @(posedge mclk);
    n_errors++;
    give_verdict();
  end
endmodule : tb_top
bind dual_timer_counter timer_checker chk (.mclk(mclk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq_ack_zero(irq_ack_zero), .irq_ack_one(irq_ack_one),
  .overflow_flag_zero(overflow_flag_zero), .overflow_flag_one(overflow_flag_one),
  .baud_tick_one(baud_tick_one));
`default_nettype wire

// >>> bench/timer_checker_asserts.sv
// checker: bus and flag properties seen at the timer/counter ports
`timescale 1ns/1ps
`default_nettype none
module timer_checker (
  input wire logic                         mclk,
  input wire logic                         rst,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [timer_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                  prdata,
  input wire logic                         pready,
  input wire logic                         pslverr,
  input wire logic                         irq_ack_zero,
  input wire logic                         irq_ack_one,
  input wire logic                         overflow_flag_zero,
  input wire logic                         overflow_flag_one,
  input wire logic                         baud_tick_one
);
  // ------------------------------
  // properties
  // ------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic acc;
  logic wr;
  assign acc = psel && penable;
  assign wr  = acc && pwrite;
  AST_READY_IN_ACCESS:
    assert property (acc |-> pready) else $error("pready low in access phase");
  AST_QUIET_IDLE:
    assert property (!acc |-> !pready && !pslverr) else $error("bus answer outside access");
  AST_UPPER_ZERO:
    assert property (acc && !pwrite |-> prdata[31:8] == 24'h000000) else $error("upper bits set");
  AST_MISALIGNED_ERR:
    assert property (acc && paddr[1:0] != 2'h0 |-> pslverr) else $error("misaligned accepted");
  AST_ERR_READ_ZERO:
    assert property (acc && pslverr && !pwrite |-> prdata == 32'h00000000)
      else $error("refused read returned data");
  AST_FLAG_ZERO_HOLDS:
    assert property (overflow_flag_zero && !irq_ack_zero && !wr |=> overflow_flag_zero)
      else $error("flag zero dropped by itself");
  AST_FLAG_ONE_HOLDS:
    assert property (overflow_flag_one && !irq_ack_one && !wr |=> overflow_flag_one)
      else $error("flag one dropped by itself");
  AST_BAUD_SINGLE:
    assert property (baud_tick_one |=> !baud_tick_one) else $error("baud pulse too long");
  AST_RESET_CLEAR:
    assert property ($fell(rst) |-> !overflow_flag_zero && !overflow_flag_one)
      else $error("flag set after reset");
  cover property ($rose(overflow_flag_zero));
  cover property ($rose(overflow_flag_one));
  cover property (baud_tick_one);
  cover property (acc && pslverr);
endmodule : timer_checker
`default_nettype wire

// >>> hdl/dual_timer_counter.sv
// module: two 16-bit timer/counters with an apb register slave
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none

// Function
// R01 - timer operation counts one per machine cycle of twelve core clocks
// R02 - counter operation counts each falling edge seen on the external count input
// R03 - falling edge recognised across two machine-cycle samples; max rate half clock; code counts at most one edge per 24 core clocks
// R04 - outside party holds each count input level at least one machine cycle
// R05 - mode register: timer 1 in bits 7..4, timer 0 in 3..0
// R06 - counting needs run bit and either gate clear or gate input high
// R07 - count select one counts external edges, zero counts machine cycles
// R08 - mode 00 13-bit, 01 16-bit, 10 8-bit reload, 11 split/halt
// R09 - 13-bit count: high byte over low five bits of low byte
// R10 - wrap from all ones to zero sets that timer's overflow flag
// R11 - setting run bit leaves count bytes unchanged
// R12 - mode 01 is mode 00 using full sixteen bits
// R13 - mode 10: low byte overflow sets flag, reloads low from high
// R14 - timer 1 in mode 11 freezes its count like run bit clear
// R15 - timer 0 mode 11 low byte is own timer with timer 0 controls
// R16 - timer 0 mode 11 high byte counts cycles via run one, sets flag one
// R17 - timer 1 still counts then, feeds baud pulse, sets no flag
// R18 - each timer runs while its run bit is set, stops when cleared
// R19 - control register: flag one b7, run one b6, flag zero b5, run zero b4
// R20 - count bytes readable and writable anytime; write loads new count
// R21 - overflow flag holds until software or interrupt acknowledge clears it
module dual_timer_counter (
  input  wire logic                         mclk,
  input  wire logic                         rst,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [timer_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         ext_count_in_zero,
  input  wire logic                         ext_count_in_one,
  input  wire logic                         ext_irq_pin_zero,
  input  wire logic                         irq_ack_zero,
  input  wire logic                         irq_ack_one,
  output logic                              overflow_flag_zero,
  output logic                              overflow_flag_one,
  output logic                              baud_tick_one
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic timer_pkg::step_result_t step(input timer_pkg::timer_mode_t m,
                                                   input timer_pkg::count_pair_t c);
    timer_pkg::step_result_t r;
    r = '{ovf: 1'b0, cnt: c};
    case (m)
      timer_pkg::MODE_13BIT: begin
        r.cnt.low[4:0] = c.low[4:0] + 5'h01; // [R09]
        if (c.low[4:0] == 5'h1F) begin
          r.cnt.high = c.high + 8'h01;
          r.ovf      = (c.high == 8'hFF); // [R10]
        end
      end
      timer_pkg::MODE_16BIT: begin
        r.cnt = c + 16'h0001; // [R12]
        r.ovf = (c == 16'hFFFF);
      end
      timer_pkg::MODE_RELOAD8: begin
        r.ovf     = (c.low == 8'hFF);
        r.cnt.low = r.ovf ? c.high : c.low + 8'h01; // [R13]
      end
      default: begin
        r.cnt.low = c.low + 8'h01; // [R15]
        r.ovf     = (c.low == 8'hFF);
      end
    endcase
    return r;
  endfunction : step

  function automatic logic hit(input logic [timer_pkg::ADDR_W-1:0] a, input logic [7:0] idx);
    return (a[1:0] == 2'h0) && (a[timer_pkg::ADDR_W-1:2] == {2'h0, idx});
  endfunction : hit

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]              mode_reg;
  logic [7:0]              control_reg;
  timer_pkg::count_pair_t  cnt0_reg, cnt1_reg;
  logic [3:0]              presc_reg;
  logic [2:0]              pin_meta, pin_sync;
  logic [1:0]              sample_reg;

  logic                    mc_tick;
  logic                    wr_en, rd_setup;
  logic                    fall0, fall1;
  timer_pkg::timer_mode_t  mode0, mode1;
  logic                    gate_in0, pulse0, pulse1, pulse_hi0;
  timer_pkg::step_result_t st0, st1;
  logic                    set_ovf0, set_ovf1;
  logic                    mapped;
  logic                    sel_control;
  logic                    sel_mode;
  logic                    sel_zero_low;
  logic                    sel_one_low;
  logic                    sel_zero_high;
  logic                    sel_one_high;
  logic [7:0]              rd_byte;

  assign mode0 = timer_pkg::timer_mode_t'(mode_reg[1:0]); // [R05] [R08]
  assign mode1 = timer_pkg::timer_mode_t'(mode_reg[timer_pkg::NIB_ONE_POS +: 2]);

  // ---------------------------------------------------------------
  // machine cycle and input sampling
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      presc_reg <= 4'h0;
    end else begin
      presc_reg <= mc_tick ? 4'h0 : presc_reg + 4'h1; // [R01]
    end
  end
  assign mc_tick = (presc_reg == timer_pkg::MC_LAST);

  // pins: {irq0, count1, count0}
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end else begin
      pin_meta <= {ext_irq_pin_zero, ext_count_in_one, ext_count_in_zero};
      pin_sync <= pin_meta;
    end
  end

  // one sample per machine cycle; an edge needs a high sample then a low one,
  // which is why input levels must last a full machine cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sample_reg <= 2'h0;
    end else if (mc_tick) begin
      sample_reg <= pin_sync[1:0]; // [R03] [R04]
    end
  end
  assign fall0 = mc_tick & sample_reg[0] & ~pin_sync[0]; // [R02] [R03]
  assign fall1 = mc_tick & sample_reg[1] & ~pin_sync[1];

  // ---------------------------------------------------------------
  // count enables
  // ---------------------------------------------------------------
  always_comb begin
    gate_in0 = (mode0 == timer_pkg::MODE_SPLIT) ? pin_sync[2] : pin_sync[0]; // [R15]
    pulse0   = control_reg[timer_pkg::CTL_RUN_ZERO]
             & (~mode_reg[timer_pkg::MODE_GATE] | gate_in0)                  // [R06] [R18]
             & (mode_reg[timer_pkg::MODE_CSEL] ? fall0 : mc_tick);          // [R07]
    pulse1   = control_reg[timer_pkg::CTL_RUN_ONE]
             & (~mode_reg[timer_pkg::NIB_ONE_POS + timer_pkg::MODE_GATE] | pin_sync[1])
             & (mode_reg[timer_pkg::NIB_ONE_POS + timer_pkg::MODE_CSEL] ? fall1 : mc_tick)
             & (mode1 != timer_pkg::MODE_SPLIT);                             // [R14]
    pulse_hi0 = (mode0 == timer_pkg::MODE_SPLIT)
              & control_reg[timer_pkg::CTL_RUN_ONE] & mc_tick;               // [R16]
    st0 = step(mode0, cnt0_reg);
    st1 = step(mode1, cnt1_reg);
  end

  assign set_ovf0 = pulse0 & st0.ovf; // [R10]
  // split mode hands flag one to the high byte of timer 0
  assign set_ovf1 = (mode0 == timer_pkg::MODE_SPLIT)
                  ? (pulse_hi0 & (cnt0_reg.high == 8'hFF))                   // [R16]
                  : (pulse1 & st1.ovf);                                      // [R17]

  // ---------------------------------------------------------------
  // apb access
  // ---------------------------------------------------------------
  // one select per register; a misaligned address selects nothing
  always_comb begin
    sel_control   = hit(paddr, timer_pkg::IDX_CONTROL);
    sel_mode      = hit(paddr, timer_pkg::IDX_MODE);
    sel_zero_low  = hit(paddr, timer_pkg::IDX_ZERO_LOW);
    sel_one_low   = hit(paddr, timer_pkg::IDX_ONE_LOW);
    sel_zero_high = hit(paddr, timer_pkg::IDX_ZERO_HIGH);
    sel_one_high  = hit(paddr, timer_pkg::IDX_ONE_HIGH);
  end
  assign mapped   = sel_control | sel_mode | sel_zero_low | sel_one_low
                  | sel_zero_high | sel_one_high;
  assign pready   = psel & penable;
  assign pslverr  = psel & penable & ~mapped;
  assign wr_en    = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable & ~pwrite;

  // read byte registered at setup, so a running count cannot change
  // under the access phase; the value seen is the one at that edge
  always_comb begin
    rd_byte = 8'h00;
    if (sel_control) begin
      rd_byte = control_reg;
    end else if (sel_mode) begin
      rd_byte = mode_reg;
    end else if (sel_zero_low) begin
      rd_byte = cnt0_reg.low; // [R20]
    end else if (sel_one_low) begin
      rd_byte = cnt1_reg.low;
    end else if (sel_zero_high) begin
      rd_byte = cnt0_reg.high;
    end else if (sel_one_high) begin
      rd_byte = cnt1_reg.high;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0;
    end else if (rd_setup) begin
      prdata <= {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_reg <= timer_pkg::RST_BYTE;
    end else if (wr_en && sel_mode) begin
      mode_reg <= pwdata[7:0];
    end
  end

  // ---------------------------------------------------------------
  // control register: hardware set beats software or ack clear
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      control_reg <= timer_pkg::RST_BYTE;
    end else begin
      if (wr_en && sel_control) begin
        control_reg <= pwdata[7:0]; // [R19]
      end else begin
        if (irq_ack_zero) begin
          control_reg[timer_pkg::CTL_OVF_ZERO] <= 1'b0; // [R21]
        end
        if (irq_ack_one) begin
          control_reg[timer_pkg::CTL_OVF_ONE] <= 1'b0;
        end
      end
      if (set_ovf0) begin
        control_reg[timer_pkg::CTL_OVF_ZERO] <= 1'b1; // [R10] [R21]
      end
      if (set_ovf1) begin
        control_reg[timer_pkg::CTL_OVF_ONE] <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // count bytes: a software write beats the increment of that byte
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt0_reg <= '0;
    end else begin
      if (pulse0) begin
        cnt0_reg.low <= st0.cnt.low; // [R11]
      end
      if (pulse0 && mode0 != timer_pkg::MODE_SPLIT) begin
        cnt0_reg.high <= st0.cnt.high;
      end
      if (pulse_hi0) begin
        cnt0_reg.high <= cnt0_reg.high + 8'h01; // [R16]
      end
      if (wr_en && sel_zero_low) begin
        cnt0_reg.low <= pwdata[7:0]; // [R20]
      end
      if (wr_en && sel_zero_high) begin
        cnt0_reg.high <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt1_reg <= '0;
    end else begin
      if (pulse1) begin
        cnt1_reg <= st1.cnt; // [R17]
      end
      if (wr_en && sel_one_low) begin
        cnt1_reg.low <= pwdata[7:0]; // [R20]
      end
      if (wr_en && sel_one_high) begin
        cnt1_reg.high <= pwdata[7:0];
      end
    end
  end

  // baud pulse keeps running while flag one belongs to split timer 0
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      baud_tick_one <= 1'b0;
    end else begin
      baud_tick_one <= pulse1 & st1.ovf; // [R17]
    end
  end

  assign overflow_flag_zero = control_reg[timer_pkg::CTL_OVF_ZERO];
  assign overflow_flag_one  = control_reg[timer_pkg::CTL_OVF_ONE];

endmodule : dual_timer_counter

`default_nettype wire

// >>> hdl/timer_pkg.sv
// package: register indices, field positions and reset values of the dual timer/counter
package timer_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address on apb is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_CONTROL   = 8'h88;
  localparam logic [7:0] IDX_MODE      = 8'h89;
  localparam logic [7:0] IDX_ZERO_LOW  = 8'h8A;
  localparam logic [7:0] IDX_ONE_LOW   = 8'h8B;
  localparam logic [7:0] IDX_ZERO_HIGH = 8'h8C;
  localparam logic [7:0] IDX_ONE_HIGH  = 8'h8D;
  localparam int         ADDR_W        = 12;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int CTL_OVF_ONE   = 7;
  localparam int CTL_RUN_ONE   = 6;
  localparam int CTL_OVF_ZERO  = 5;
  localparam int CTL_RUN_ZERO  = 4;
  localparam int MODE_GATE     = 3;
  localparam int MODE_CSEL     = 2;
  localparam int MODE_HI_BIT   = 1;
  localparam int MODE_LO_BIT   = 0;
  localparam int NIB_ONE_POS   = 4;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int         MC_CLOCKS = 12;
  localparam logic [3:0] MC_LAST   = 4'(MC_CLOCKS - 1);

  typedef enum logic [1:0] {
    MODE_13BIT,
    MODE_16BIT,
    MODE_RELOAD8,
    MODE_SPLIT
  } timer_mode_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } count_pair_t;

  typedef struct packed {
    logic        ovf;
    count_pair_t cnt;
  } step_result_t;

endpackage : timer_pkg
